// ==== ips_regs.svh ====
`ifndef IPS_REGS_SVH
`define IPS_REGS_SVH

// register indices; byte address is four times the index
`define IPS_IDX_STATUS      10'h000
`define IPS_IDX_MASK        10'h001
`define IPS_IDX_INSVC       10'h002
`define IPS_IDX_PRIO_LOW_A  10'h0EF
`define IPS_IDX_PRIO_HIGH_A 10'h0F7
`define IPS_IDX_PRIO_LOW_B  10'h0FE
`define IPS_IDX_PRIO_HIGH_B 10'h0FF

// reset values
`define IPS_PRIO_RESET      8'h00
`define IPS_EVT_RESET       3'h0

// writable bits of the second register pair
`define IPS_PRIO_B_MASK     8'h07

// bit positions in the first register pair
`define IPS_BIT_TIMER2      7
`define IPS_BIT_SPI         6
`define IPS_BIT_FAULT_BRAKE 5
`define IPS_BIT_WATCHDOG    4
`define IPS_BIT_PWM         3
`define IPS_BIT_CAPTURE     2
`define IPS_BIT_PIN_IRQ     1
`define IPS_BIT_I2C         0

// bit positions in the second register pair
`define IPS_BIT_WAKEUP      2
`define IPS_BIT_TIMER3      1
`define IPS_BIT_UART1       0

// status and mask bits
`define IPS_EVT_ACCEPT      0
`define IPS_EVT_WITHHELD    1
`define IPS_EVT_EXIT        2

// vector addresses
`define IPS_VEC_WATCHDOG    16'h0053
`define IPS_VEC_I2C         16'h0033
`define IPS_VEC_PIN_IRQ     16'h003B
`define IPS_VEC_FAULT_BRAKE 16'h0073
`define IPS_VEC_SPI         16'h004B
`define IPS_VEC_TIMER2      16'h002B
`define IPS_VEC_CAPTURE     16'h0063
`define IPS_VEC_PWM         16'h006B
`define IPS_VEC_UART1       16'h007B
`define IPS_VEC_TIMER3      16'h0083
`define IPS_VEC_WAKEUP      16'h008B

// sources whose flag is cleared on entry (timer 3 only among these)
`define IPS_AUTO_CLEAR      11'h200

// timing in clock cycles
`define IPS_CALL_CYCLES     3'h4

`endif

// ==== ips_pkg.sv ====
package ips_pkg;

	// source index = natural order: 0 watchdog, 1 i2c, 2 pin, 3 fault brake, 4 spi,
	// 5 timer2, 6 capture, 7 pwm, 8 uart1, 9 timer3, 10 wakeup timer
	localparam int NUM_SRC = 11;

	typedef logic [1:0] ips_level_type;

	typedef struct packed {
		logic                 hsel;
		logic [31:0]          haddr;
		logic [1:0]           htrans;
		logic                 hwrite;
		logic [2:0]           hsize;
		logic                 hready;
		logic [31:0]          hwdata;
	} ips_ahb_in_type;

	typedef struct packed {
		logic                 hreadyout;
		logic                 hresp;
		logic [31:0]          hrdata;
	} ips_ahb_out_type;

	typedef struct packed {
		logic [NUM_SRC-1:0]   flags;
		logic                 instr_last;
		logic                 cfg_write;
		logic                 irq_exit_instr;
		logic                 plain_sub_exit;
	} ips_cpu_in_type;

	typedef struct packed {
		logic                 long_call_vector;
		logic                 call_busy;
		logic [15:0]          vector;
		logic [NUM_SRC-1:0]   flag_clear;
		logic [3:0]           in_service;
	} ips_call_type;

	typedef struct packed {
		logic [7:0]           prio_low_a;
		logic [7:0]           prio_high_a;
		logic [7:0]           prio_low_b;
		logic [7:0]           prio_high_b;
		logic [2:0]           status;
		logic [2:0]           mask;
		logic                 irq;
		logic                 wr_pend;
		logic [9:0]           wr_idx;
		logic [2:0]           call_cnt;
		ips_ahb_out_type      bus;
		ips_call_type         call;
	} ips_state_type;

endpackage

// ==== ips_top.sv ====
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
// Function
// [RL1] level joins low bit with matching high bit
// [RL2] pair 00 to 11 gives levels zero to three
// [RL3] first low register bit positions per source
// [RL4] first high register same order, reset zero
// [RL5] second low register: wakeup, timer3, uart1
// [RL6] second high register: same three sources
// [RL7] equal levels: lowest natural number wins
// [RL8] sample, poll and resolve every clock
// [RL9] withhold call if equal/higher level serving
// [RL10] call only on instruction's final cycle
// [RL11] no call on config write or exit
// [RL12] blocked requests are never remembered
// [RL13] long call pushes counter, loads vector
// [RL14] timer flags cleared on entry, timer2 not; code clears only timer3, not the wakeup timer
// [RL15] interrupt exit frees current service level
// [RL16] plain return leaves service state unchanged
// [RL17] call lasts four cycles, response five minimum
// [RL18] single interrupt response within sixteen cycles
// [RL19] unused upper bits read zero, ignore writes
`include "ips_regs.svh"

module ips_top (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire ips_pkg::ips_ahb_in_type  ahb_in,
	output      ips_pkg::ips_ahb_out_type ahb_out,
	input  wire ips_pkg::ips_cpu_in_type  cpu,
	output      ips_pkg::ips_call_type    call,
	output      logic                irq
);
	import ips_pkg::*;

	// sources whose flag the call clears; kept at source width so one bit can be picked
	localparam logic [NUM_SRC-1:0] auto_clr = `IPS_AUTO_CLEAR;

	ips_state_type s;
	ips_state_type next_s;

	// low and high bit vectors in natural source order
	logic [NUM_SRC-1:0] low_vec;
	logic [NUM_SRC-1:0] high_vec;
	ips_level_type      win_lvl;
	logic [3:0]         win_idx;
	logic               found;
	logic               blocked;
	logic               accept;
	logic               bus_prio_wr;
	logic [2:0]         evt;

	// level of one source from the two bit vectors
	function automatic ips_level_type level_of(input logic [NUM_SRC-1:0] lo,
		input logic [NUM_SRC-1:0] hi, input int idx);
		return {hi[idx], lo[idx]}; // RL2
	endfunction

	// in-service levels equal to or above a level
	function automatic logic [3:0] at_or_above(input ips_level_type lvl);
		logic [3:0] m;
		m = 4'hF << lvl;
		return m;
	endfunction

	// vector address per source
	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		logic [15:0] v;
		case (idx)
			4'h0: v = `IPS_VEC_WATCHDOG;
			4'h1: v = `IPS_VEC_I2C;
			4'h2: v = `IPS_VEC_PIN_IRQ;
			4'h3: v = `IPS_VEC_FAULT_BRAKE;
			4'h4: v = `IPS_VEC_SPI;
			4'h5: v = `IPS_VEC_TIMER2;
			4'h6: v = `IPS_VEC_CAPTURE;
			4'h7: v = `IPS_VEC_PWM;
			4'h8: v = `IPS_VEC_UART1;
			4'h9: v = `IPS_VEC_TIMER3;
			default: v = `IPS_VEC_WAKEUP;
		endcase
		return v;
	endfunction

	// gather priority bits per source
	always_comb begin
		low_vec = {s.prio_low_b[`IPS_BIT_WAKEUP], s.prio_low_b[`IPS_BIT_TIMER3], // RL5
			s.prio_low_b[`IPS_BIT_UART1], s.prio_low_a[`IPS_BIT_PWM],
			s.prio_low_a[`IPS_BIT_CAPTURE], s.prio_low_a[`IPS_BIT_TIMER2], // RL3
			s.prio_low_a[`IPS_BIT_SPI], s.prio_low_a[`IPS_BIT_FAULT_BRAKE],
			s.prio_low_a[`IPS_BIT_PIN_IRQ], s.prio_low_a[`IPS_BIT_I2C],
			s.prio_low_a[`IPS_BIT_WATCHDOG]};
		high_vec = {s.prio_high_b[`IPS_BIT_WAKEUP], s.prio_high_b[`IPS_BIT_TIMER3], // RL6
			s.prio_high_b[`IPS_BIT_UART1], s.prio_high_a[`IPS_BIT_PWM],
			s.prio_high_a[`IPS_BIT_CAPTURE], s.prio_high_a[`IPS_BIT_TIMER2], // RL4
			s.prio_high_a[`IPS_BIT_SPI], s.prio_high_a[`IPS_BIT_FAULT_BRAKE],
			s.prio_high_a[`IPS_BIT_PIN_IRQ], s.prio_high_a[`IPS_BIT_I2C],
			s.prio_high_a[`IPS_BIT_WATCHDOG]};
	end

	// resolve priority on the live flags; walking downward lets the lowest
	// index win a tie, and nothing is kept from earlier polls
	always_comb begin
		found = 1'b0;
		win_lvl = 2'h0;
		win_idx = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (cpu.flags[i] && (!found || level_of(low_vec, high_vec, i) >= win_lvl)) begin // RL7 RL8 RL12
				found = 1'b1;
				win_lvl = level_of(low_vec, high_vec, i); // RL1
				win_idx = 4'(i);
			end
		end
	end

	// a bus write into a priority register counts like a cpu config write
	assign bus_prio_wr = s.wr_pend && (s.wr_idx == `IPS_IDX_PRIO_LOW_A
		|| s.wr_idx == `IPS_IDX_PRIO_HIGH_A || s.wr_idx == `IPS_IDX_PRIO_LOW_B
		|| s.wr_idx == `IPS_IDX_PRIO_HIGH_B);
	assign blocked = |(s.call.in_service & at_or_above(win_lvl)); // RL9
	assign accept = found && !blocked && cpu.instr_last // RL10
		&& !cpu.cfg_write && !cpu.irq_exit_instr && !bus_prio_wr // RL11
		&& s.call_cnt == 3'h0;

	// next state
	always_comb begin
		logic [9:0]  idx;
		logic [31:0] rd;
		logic [2:0]  w1c;
		idx = ahb_in.haddr[11:2];
		rd = 32'h0;
		w1c = 3'h0;
		next_s = s;
		next_s.call.long_call_vector = 1'b0;
		next_s.call.flag_clear = '0;
		next_s.bus.hreadyout = 1'b1;
		next_s.bus.hresp = 1'b0;
		evt = 3'h0;

		// data phase of a write
		if (s.wr_pend) begin
			case (s.wr_idx)
				`IPS_IDX_PRIO_LOW_A:  next_s.prio_low_a = ahb_in.hwdata[7:0]; // RL3
				`IPS_IDX_PRIO_HIGH_A: next_s.prio_high_a = ahb_in.hwdata[7:0]; // RL4
				`IPS_IDX_PRIO_LOW_B:
					next_s.prio_low_b = ahb_in.hwdata[7:0] & `IPS_PRIO_B_MASK; // RL19
				`IPS_IDX_PRIO_HIGH_B:
					next_s.prio_high_b = ahb_in.hwdata[7:0] & `IPS_PRIO_B_MASK; // RL19
				`IPS_IDX_MASK:        next_s.mask = ahb_in.hwdata[2:0];
				`IPS_IDX_STATUS:      w1c = ahb_in.hwdata[2:0];
				default: ;
			endcase
		end

		// the call sequence; the sequencer pushes the counter while busy
		if (accept) begin
			next_s.call_cnt = `IPS_CALL_CYCLES; // RL17
			next_s.call.long_call_vector = 1'b1; // RL13
			next_s.call.vector = vector_of(win_idx); // RL13
			next_s.call.in_service[win_lvl] = 1'b1;
			next_s.call.flag_clear[win_idx] = auto_clr[win_idx]; // RL14
			evt[`IPS_EVT_ACCEPT] = 1'b1;
		end else if (s.call_cnt != 3'h0) begin
			next_s.call_cnt = s.call_cnt - 3'h1;
		end
		if (found && cpu.instr_last && !accept) begin
			evt[`IPS_EVT_WITHHELD] = 1'b1;
		end
		next_s.call.call_busy = next_s.call_cnt != 3'h0;

		// only the exit instruction frees a level; a plain return does not
		if (cpu.irq_exit_instr && cpu.instr_last) begin
			for (int l = 0; l < 4; l++) begin
				if (s.call.in_service[l] && (s.call.in_service >> (l + 1)) == 4'h0) begin
					next_s.call.in_service[l] = 1'b0; // RL15 RL16
				end
			end
			evt[`IPS_EVT_EXIT] = 1'b1;
		end

		// sticky status: a new event wins over a clear in the same cycle
		next_s.status = (s.status & ~w1c) | evt;
		next_s.irq = |(next_s.status & next_s.mask);

		// address phase; read data taken from the updated copy so a read
		// right after a write sees the new value
		next_s.wr_pend = 1'b0;
		if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1]) begin
			if (ahb_in.hwrite) begin
				next_s.wr_pend = 1'b1;
				next_s.wr_idx = idx;
			end else begin
				case (idx)
					`IPS_IDX_PRIO_LOW_A:  rd[7:0] = next_s.prio_low_a;
					`IPS_IDX_PRIO_HIGH_A: rd[7:0] = next_s.prio_high_a;
					`IPS_IDX_PRIO_LOW_B:  rd[7:0] = next_s.prio_low_b;
					`IPS_IDX_PRIO_HIGH_B: rd[7:0] = next_s.prio_high_b;
					`IPS_IDX_STATUS:      rd[2:0] = next_s.status;
					`IPS_IDX_MASK:        rd[2:0] = next_s.mask;
					`IPS_IDX_INSVC:       rd[3:0] = next_s.call.in_service;
					default: rd = 32'h0;
				endcase
				next_s.bus.hrdata = rd;
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.prio_low_a <= `IPS_PRIO_RESET; // RL4
			s.prio_high_a <= `IPS_PRIO_RESET;
			s.prio_low_b <= `IPS_PRIO_RESET;
			s.prio_high_b <= `IPS_PRIO_RESET;
			s.status <= `IPS_EVT_RESET;
			s.mask <= `IPS_EVT_RESET;
			s.bus.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign ahb_out = s.bus;
	assign call = s.call;
	assign irq = s.irq;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	call_length_a: assert property (call.long_call_vector |-> call.call_busy [*4] ##1 !call.call_busy) // RL17
		else $error("call did not last four cycles");
	final_cycle_a: assert property (call.long_call_vector |-> $past(cpu.instr_last)) // RL10
		else $error("call outside final instruction cycle");
	no_cfg_call_a: assert property (call.long_call_vector
		|-> !$past(cpu.cfg_write) && !$past(cpu.irq_exit_instr)) // RL11
		else $error("call after config write or exit");
	poll_each_cycle_a: assert property (cpu.instr_last && |cpu.flags && !call.call_busy
		&& call.in_service == 4'h0 && !cpu.cfg_write && !cpu.irq_exit_instr && !bus_prio_wr
		|=> call.long_call_vector) // RL8
		else $error("valid request not answered next cycle");
	level_block_a: assert property (call.long_call_vector |-> !$past(blocked)) // RL9
		else $error("call taken while equal level served");
	exit_frees_a: assert property (cpu.irq_exit_instr && cpu.instr_last && |call.in_service
		|=> $countones(call.in_service) == $countones($past(call.in_service)) - 1) // RL15
		else $error("exit did not free one level");
	plain_return_a: assert property (cpu.plain_sub_exit && !cpu.irq_exit_instr && !accept
		|=> call.in_service == $past(call.in_service)) // RL16
		else $error("plain return changed service state");
	timer_clear_a: assert property (call.long_call_vector
		|-> call.flag_clear[9] == (call.vector == `IPS_VEC_TIMER3) && !call.flag_clear[5]) // RL14
		else $error("wrong flag cleared on entry");
	unused_bits_a: assert property (s.prio_low_b[7:3] == 5'h0 && s.prio_high_b[7:3] == 5'h0) // RL19
		else $error("unused priority bits set");
	tie_break_a: assert property (accept && cpu.flags[0]
		&& level_of(low_vec, high_vec, 0) == win_lvl |-> win_idx == 4'h0) // RL7
		else $error("tie not won by lowest source");
	response_a: assert property ($rose(cpu.flags[0]) && accept
		|=> call.call_busy [*4] ##1 !call.call_busy) // RL18
		else $error("response exceeds bound");

	call_cover_c: cover property (call.long_call_vector);
	nest_cover_c: cover property (call.long_call_vector ##[1:40] call.long_call_vector
		&& $countones(call.in_service) == 2);
	exit_cover_c: cover property (cpu.irq_exit_instr && cpu.instr_last && |call.in_service);
	irq_cover_c: cover property ($rose(irq));
endmodule

// ==== ips_cpu_model.sv ====
`timescale 1ns/1ns
// instruction sequencer stand-in: fixed-length instructions, stalled during the call
module ips_cpu_model #(
	parameter int LEN = 3
) (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic [10:0]            req,
	input  wire logic [1:0]             kind,
	input  wire ips_pkg::ips_call_type  call,
	output      ips_pkg::ips_cpu_in_type cpu
);
	import ips_pkg::*;
	logic [2:0] cnt;
	// the long call owns the core for its whole length, so no instruction ends meanwhile
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= 3'h0;
		else if (call.call_busy || cnt == 3'(LEN - 1))
			cnt <= 3'h0;
		else
			cnt <= cnt + 3'h1;
	end
	// kind: 0 plain, 1 config write, 2 interrupt return, 3 plain return
	always_comb begin
		cpu.flags = req;
		cpu.instr_last = (cnt == 3'(LEN - 1)) && !call.call_busy;
		cpu.cfg_write = kind == 2'h1;
		cpu.irq_exit_instr = kind == 2'h2;
		cpu.plain_sub_exit = kind == 2'h3;
	end
endmodule

// ==== interrupt_priority_service_tb.sv ====
`timescale 1ns/1ns
`include "ips_regs.svh"
module interrupt_priority_service_tb;
	import ips_pkg::*;
	localparam int BP [11] = '{4, 0, 1, 5, 6, 7, 2, 3, 0, 1, 2};
	localparam logic [15:0] VEC [11] = '{`IPS_VEC_WATCHDOG, `IPS_VEC_I2C, `IPS_VEC_PIN_IRQ,
		`IPS_VEC_FAULT_BRAKE, `IPS_VEC_SPI, `IPS_VEC_TIMER2, `IPS_VEC_CAPTURE,
		`IPS_VEC_PWM, `IPS_VEC_UART1, `IPS_VEC_TIMER3, `IPS_VEC_WAKEUP};
	localparam logic [11:0] RA [4] = '{{`IPS_IDX_PRIO_LOW_A, 2'h0}, {`IPS_IDX_PRIO_HIGH_A, 2'h0},
		{`IPS_IDX_PRIO_LOW_B, 2'h0}, {`IPS_IDX_PRIO_HIGH_B, 2'h0}};
	logic            hclk;
	logic            hresetn;
	ips_ahb_in_type  bm;
	ips_ahb_in_type  ain;
	ips_ahb_out_type ao;
	ips_cpu_in_type  cpu;
	ips_call_type    call;
	logic            irq;
	logic [10:0]     req;
	logic [1:0]      kind;
	logic [31:0]     rv;
	logic [10:0]     fc;
	logic            pl;
	int              miscompares = 0;
	int              num_checks = 0;
	int              npulse = 0;
	// single slave: its ready is the bus ready
	assign ain = {bm.hsel, bm.haddr, bm.htrans, bm.hwrite, bm.hsize, ao.hreadyout, bm.hwdata};
	ips_top i_dut (.hclk(hclk), .hresetn(hresetn), .ahb_in(ain), .ahb_out(ao), .cpu(cpu),
		.call(call), .irq(irq));
	ips_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .req(req), .kind(kind), .call(call),
		.cpu(cpu));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// sampled mid-cycle so registered outputs have settled; pl lags one cycle
	always @(negedge hclk) begin
		if (call.long_call_vector === 1'b1)
			npulse++;
		pl <= cpu.instr_last;
	end
	task end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// ready is judged just before the edge that takes it
	task rdy;
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			if (n > 20) begin
				miscompares++;
				end_sim;
			end
		end while (ao.hreadyout !== 1'b1);
		rv = ao.hrdata;
		@(posedge hclk);
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		bm.hsel <= 1'b1;
		bm.haddr <= {20'h0, a};
		bm.hwrite <= w;
		bm.hsize <= 3'h2;
		bm.htrans <= 2'h2;
		rdy;
		bm.htrans <= 2'h0;
		bm.hwdata <= {24'h0, d};
		rdy;
	endtask
	task wp;
		int n;
		int b;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			if (n > 16) begin
				miscompares++;
				end_sim;
			end
		end while (call.long_call_vector !== 1'b1);
		chk("last", 32'(pl), 32'h1);
		fc = call.flag_clear;
		b = 0;
		while (call.call_busy === 1'b1 && b < 8) begin
			b++;
			@(negedge hclk);
		end
		chk("busy", 32'(b), 32'h4);
		@(posedge hclk);
	endtask
	task ex;
		int n;
		n = 0;
		req <= 11'h0;
		kind <= 2'h2;
		do begin
			@(negedge hclk);
			n++;
		end while (call.in_service !== 4'h0 && n < 12);
		chk("exit", 32'(call.in_service), 32'h0);
		@(posedge hclk);
		kind <= 2'h0;
	endtask
	task t_regs;
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, RA[k], 8'h00);
			chk("prio rst", rv, 32'h0);
			bus(1'b1, RA[k], 8'hFF);
			bus(1'b0, RA[k], 8'h00);
			chk("prio rw", rv, k < 2 ? 32'hFF : 32'h07);
		end
		bus(1'b0, 12'h100, 8'h00);
		chk("unmapped", rv, 32'h0);
	endtask
	// each source alone at level three must win against all others
	task t_src;
		logic [7:0] m;
		for (int i = 0; i < 11; i++) begin
			m = 8'h01 << BP[i];
			bus(1'b1, RA[0], i < 8 ? m : 8'h00);
			bus(1'b1, RA[1], i < 8 ? m : 8'h00);
			bus(1'b1, RA[2], i < 8 ? 8'h00 : m);
			bus(1'b1, RA[3], i < 8 ? 8'h00 : m);
			req <= 11'h7FF;
			wp;
			chk("vector", 32'(call.vector), 32'(VEC[i]));
			chk("clear", 32'(fc), i == 9 ? 32'h200 : 32'h0);
			chk("insvc", 32'(call.in_service), 32'h8);
			ex;
		end
	endtask
	task t_tie;
		int p;
		for (int k = 0; k < 4; k++)
			bus(1'b1, RA[k], 8'h00);
		req <= 11'h7FF;
		wp;
		chk("tie", 32'(call.vector), 32'(`IPS_VEC_WATCHDOG));
		chk("lvl0", 32'(call.in_service), 32'h1);
		ex;
		bus(1'b1, RA[0], 8'h01);
		bus(1'b1, RA[1], 8'h02);
		req <= 11'h006;
		wp;
		chk("lvl2", 32'(call.vector), 32'(`IPS_VEC_PIN_IRQ));
		chk("insvc2", 32'(call.in_service), 32'h4);
		p = npulse;
		kind <= 2'h3;
		repeat (12) @(posedge hclk);
		chk("ret", 32'(call.in_service), 32'h4);
		chk("held", 32'(npulse), 32'(p));
		bus(1'b0, 12'h000, 8'h00);
		chk("withheld", rv & 32'h3, 32'h3);
		ex;
		repeat (12) @(posedge hclk);
		chk("forgot", 32'(npulse), 32'(p));
	endtask
	task t_gate;
		int p;
		p = npulse;
		req <= 11'h7FF;
		kind <= 2'h1;
		repeat (12) @(posedge hclk);
		kind <= 2'h2;
		repeat (12) @(posedge hclk);
		chk("gated", 32'(npulse), 32'(p));
		kind <= 2'h0;
		wp;
		chk("ungated", 32'(call.vector), 32'(`IPS_VEC_PIN_IRQ));
		ex;
	endtask
	task t_irq;
		bus(1'b0, 12'h000, 8'h00);
		chk("status", rv, 32'h7);
		bus(1'b1, 12'h004, 8'h04);
		repeat (2) @(posedge hclk);
		chk("irq on", 32'(irq), 32'h1);
		bus(1'b1, 12'h000, 8'h04);
		repeat (2) @(posedge hclk);
		chk("irq off", 32'(irq), 32'h0);
		bus(1'b0, 12'h000, 8'h00);
		chk("w1c", rv, 32'h3);
	endtask
	initial begin
		bm = '0;
		req = 11'h0;
		kind = 2'h0;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_src;
		t_tie;
		t_gate;
		t_irq;
		end_sim;
	end
endmodule
